// file: instruction_core.v
// Instruction sequencer and execution for the 8-bit core
// Assumes asynchronous program memory and data space read in the same cycle
`timescale 1ns/1ps
`include "core_defines.vh"

module instruction_core #(
  parameter DEPTH = `STACK_DEPTH
) (
  input  wire        clock,
  input  wire        reset_n,
  output wire [11:0] prog_addr,
  input  wire [7:0]  prog_data,
  output reg  [7:0]  data_addr,
  input  wire [7:0]  data_rdata,
  output reg  [7:0]  data_wdata,
  output wire        data_we,
  input  wire        watchdog_on,
  input  wire        wake,
  output reg  [7:0]  acc_value,
  output reg         zero_flag,
  output reg         carry_flag,
  output wire        waiting,
  output wire        stopped
);

  localparam RUN  = 2'h0;
  localparam WAIT = 2'h1;
  localparam STOP = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg [1:0]  state;
  reg [2:0]  step;
  reg [11:0] pc;
  reg [7:0]  opcode;
  reg [7:0]  byte2;
  reg [7:0]  byte3;
  reg [7:0]  pointer;
  reg [2:0]  sp;
  reg [13:0] stack [0:DEPTH-1];

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  reg [2:0]  cycles;
  reg [1:0]  len;
  reg [3:0]  func;
  reg [1:0]  b_src;
  reg        addr_ptr;
  reg        addr_short;
  reg        wr_mem;
  reg        wr_acc;
  reg        upd_z;
  reg        upd_c;
  reg        bit_write;
  reg        bit_test;
  reg        is_branch;
  reg        is_jump;
  reg        is_call;
  reg        is_ret;
  reg        is_interrupt_return_op;
  reg        is_stop;
  reg        is_wait;

  wire [2:0] grp  = opcode[7:5];
  wire [2:0] sub  = opcode[4:2];
  wire [1:0] mode = opcode[1:0];

  always @* begin
    cycles     = `CYC_NORMAL;
    len        = 2'd1;
    func       = `ALU_PASS;
    b_src      = 2'd0;
    addr_ptr   = 1'b0;
    addr_short = 1'b0;
    wr_mem     = 1'b0;
    wr_acc     = 1'b0;
    upd_z      = 1'b0;
    upd_c      = 1'b0;
    bit_write  = 1'b0;
    bit_test   = 1'b0;
    is_branch  = 1'b0;
    is_jump    = 1'b0;
    is_call    = 1'b0;
    is_ret     = 1'b0;
    is_interrupt_return_op    = 1'b0;
    is_stop    = 1'b0;
    is_wait    = 1'b0;
    if (!grp[2]) begin
      cycles    = `CYC_SHORT; // RQ7
      is_branch = 1'b1; // RQ17
    end else if (grp == `GRP_JUMP) begin
      len     = 2'd2;
      is_jump = 1'b1; // RQ12
      is_call = opcode[4];
    end else if (grp == `GRP_BIT) begin
      if (opcode[4]) begin
        cycles   = `CYC_BIT_TEST; // RQ8
        len      = 2'd3;
        bit_test = 1'b1;
      end else begin
        len       = 2'd2; // RQ10
        bit_write = 1'b1;
        wr_mem    = 1'b1;
      end
    end else if (grp == `GRP_ALU) begin
      addr_ptr = (mode == `MODE_IND_X) || (mode == `MODE_IND_Y);
      len      = addr_ptr ? 2'd1 : 2'd2; // RQ13
      b_src    = (mode == `MODE_IMM) ? 2'd1 : 2'd0;
      upd_z    = 1'b1;
      case (sub)
        `AOP_LOAD: wr_acc = 1'b1; // RQ2
        `AOP_ADD: begin
          func   = `ALU_ADD;
          wr_acc = 1'b1;
          upd_c  = 1'b1; // RQ4
        end
        `AOP_AND: begin
          func   = `ALU_AND;
          wr_acc = 1'b1;
          upd_c  = 1'b1;
        end
        `AOP_CMP: begin
          func  = `ALU_SUB;
          upd_c = 1'b1;
        end
        `AOP_SUB: begin
          func   = `ALU_SUB;
          wr_acc = 1'b1;
          upd_c  = 1'b1;
        end
        `AOP_STORE: begin
          wr_mem = 1'b1;
          if (mode == `MODE_IMM) begin
            len   = 2'd3; // RQ3
            b_src = 2'd3;
            upd_z = 1'b0;
          end else begin
            b_src = 2'd2; // RQ2
          end
        end
        default: begin
          func   = (sub == `AOP_INC) ? `ALU_INC : `ALU_DEC;
          wr_mem = (mode != `MODE_IMM); // RQ5
          upd_z  = (mode != `MODE_IMM);
        end
      endcase
    end else begin
      addr_short = 1'b1; // RQ13
      case (sub)
        `SOP_LOAD: begin
          wr_acc = 1'b1;
          upd_z  = 1'b1;
        end
        `SOP_STORE: begin
          b_src  = 2'd2;
          wr_mem = 1'b1;
          upd_z  = 1'b1;
        end
        `SOP_INC, `SOP_DEC: begin
          func   = (sub == `SOP_INC) ? `ALU_INC : `ALU_DEC;
          wr_mem = 1'b1;
          upd_z  = 1'b1; // RQ5
        end
        `SOP_ACC: begin
          wr_acc = 1'b1;
          upd_z  = 1'b1;
          upd_c  = 1'b1; // RQ6
          case (mode)
            2'd0: func = `ALU_COM;
            2'd1: func = `ALU_RLC;
            2'd2: begin
              func = `ALU_SLA;
              len  = 2'd2;
            end
            default: begin
              func = `ALU_CLR; // RQ5
              len  = 2'd2;
            end
          endcase
        end
        `SOP_CTRL: begin
          cycles  = `CYC_SHORT; // RQ11
          is_ret  = (mode == 2'd1) || (mode == 2'd2);
          is_interrupt_return_op = (mode == 2'd2);
          is_stop = (mode == 2'd3);
        end
        `SOP_MISC: begin
          case (mode)
            2'd0: begin
              cycles  = `CYC_SHORT;
              is_wait = 1'b1;
            end
            2'd1, 2'd2: begin
              len    = 2'd2;
              b_src  = 2'd2;
              func   = (mode == 2'd1) ? `ALU_INC : `ALU_DEC;
              wr_acc = 1'b1;
              upd_z  = 1'b1; // RQ5
            end
            default: begin
              len        = 2'd3;
              func       = `ALU_CLR;
              wr_mem     = 1'b1;
              addr_short = 1'b0; // RQ5
            end
          endcase
        end
        default: cycles = `CYC_SHORT;
      endcase
    end
  end // RQ1

  ////////////////////////////////////////////////////////////////////////////
  // Operands and ALU
  wire        last = (state == RUN) && (step != 3'd0) && (step == cycles - 3'd1);
  wire [2:0]  bsel = opcode[2:0];
  reg  [7:0]  b_val;
  wire [7:0]  alu_out;
  wire        alu_carry;
  wire        alu_zero;
  wire        tested = data_rdata[bsel];

  always @* begin
    case (b_src)
      2'd0:    b_val = data_rdata;
      2'd1:    b_val = byte2;
      2'd2:    b_val = acc_value;
      default: b_val = byte3;
    endcase
  end

  always @* begin
    if (step == 3'd1 && addr_ptr)
      data_addr = {7'h40, mode[0]};
    else if (addr_short)
      data_addr = {`SHORT_BASE, mode};
    else if (addr_ptr)
      data_addr = pointer;
    else
      data_addr = byte2;
  end

  always @* begin
    if (bit_write)
      data_wdata = opcode[3] ? (data_rdata | (8'h01 << bsel))
                             : (data_rdata & ~(8'h01 << bsel)); // RQ10
    else
      data_wdata = alu_out;
  end

  assign data_we   = last && wr_mem;
  assign prog_addr = pc + {9'h000, step};
  assign waiting   = (state == WAIT);
  assign stopped   = (state == STOP);

  alu8 u_alu (
    .func      (func),
    .a         (acc_value),
    .b         (b_val),
    .carry_in  (carry_flag),
    .result    (alu_out),
    .carry_out (alu_carry),
    .zero      (alu_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next program counter
  reg        taken;
  reg [11:0] next_pc;

  always @* begin
    taken   = 1'b0;
    next_pc = pc + {10'h000, len};
    if (is_branch) begin
      case (grp[1:0])
        `COND_ZERO_CLEAR:  taken = !zero_flag;
        `COND_ZERO_SET:    taken = zero_flag;
        `COND_CARRY_CLEAR: taken = !carry_flag;
        default:           taken = carry_flag;
      endcase
      if (taken)
        next_pc = opcode[4] ? pc - {8'h00, opcode[3:0]}
                            : pc + {8'h00, opcode[3:0]} + 12'h001; // RQ14
    end else if (bit_test) begin
      if (tested == opcode[3])
        next_pc = pc + 12'h002 + {{4{byte3[7]}}, byte3}; // RQ9
    end else if (is_jump) begin
      next_pc = {opcode[3:0], byte2}; // RQ12
    end else if (is_ret) begin
      next_pc = stack[sp - 3'd1][11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state      <= RUN;
      step       <= 3'd0;
      pc         <= `RESET_PC;
      opcode     <= 8'h00;
      byte2      <= 8'h00;
      byte3      <= 8'h00;
      pointer    <= 8'h00;
      sp         <= 3'd0;
      acc_value  <= 8'h00;
      zero_flag  <= 1'b0;
      carry_flag <= 1'b0;
    end else if (state != RUN) begin
      if (wake)
        state <= RUN;
    end else if (last) begin
      step <= 3'd0;
      pc   <= next_pc;
      if (wr_acc)
        acc_value <= alu_out; // RQ2
      if (upd_z)
        zero_flag <= alu_zero; // RQ18
      if (upd_c)
        carry_flag <= alu_carry;
      if (bit_test)
        carry_flag <= tested; // RQ8
      if (is_call) begin
        stack[(sp == DEPTH) ? sp - 3'd1 : sp] <= {zero_flag, carry_flag, pc + 12'h002}; // RQ16
        if (sp != DEPTH)
          sp <= sp + 3'd1;
      end
      if (is_ret && sp != 3'd0)
        sp <= sp - 3'd1;
      if (is_interrupt_return_op) begin
        zero_flag  <= stack[sp - 3'd1][13]; // RQ11
        carry_flag <= stack[sp - 3'd1][12];
      end
      if (is_wait || (is_stop && watchdog_on))
        state <= WAIT; // RQ15
      else if (is_stop)
        state <= STOP;
    end else begin
      step <= step + 3'd1;
      case (step)
        3'd0: opcode <= prog_data;
        3'd1: begin
          byte2 <= prog_data;
          if (addr_ptr)
            pointer <= data_rdata;
        end
        3'd2: byte3 <= prog_data;
        default: byte3 <= byte3;
      endcase
    end
  end

endmodule

// file: core_defines.vh
// Constants for the 8-bit instruction core: opcode fields, ALU codes, cycles, addresses
// Assumes inclusion by core and ALU files; definitions only
//
// Behaviour
// [RQ1] Decode forty basic operations over nine addressing modes in six classes.
// [RQ2] Load/store moves a byte with accumulator in 4 cycles; zero updated, carry kept.
// [RQ3] Immediate load writes a byte to any data address, 3 bytes, no flags.
// [RQ4] Add, and, compare, subtract use accumulator; 4 cycles; zero and carry updated.
// [RQ5] Clear, inc, dec reach any address; inc/dec zero only; clear A both flags.
// [RQ6] Complement, rotate through carry, shift left act on accumulator; both flags.
// [RQ7] Flag branches are one byte, 2 cycles, reach -15..+16, no flags.
// [RQ8] Bit-test branches are three bytes, 5 cycles; tested bit goes to carry.
// [RQ9] Bit-test displacement is signed 8-bit, reach -126..+129 from the instruction.
// [RQ10] Bit set/clear changes one selected bit of any byte; 2 bytes, 4 cycles.
// [RQ11] Nop, return, stop, wait take 2 cycles; interrupt return restores both flags.
// [RQ12] Jump and call carry a 12-bit target covering all program space.
// [RQ13] Lengths: short/indirect 1, direct/acc-immediate 2, memory-immediate 3 bytes.
// [RQ14] Branch goes to target only when condition holds, else next instruction.
// [RQ15] With watchdog selected, stop is replaced by wait.
// [RQ16] Return addresses sit in a six-entry 12-bit hardware stack.
// [RQ17] Short branch opcode: 3-bit condition, direction bit, 4-bit span; code decodes a 2-bit condition from opcode[6:5] with opcode[7] clear.
// [RQ18] Zero flag set when the 8-bit result is zero, cleared otherwise.
`ifndef CORE_DEFINES_VH
`define CORE_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Opcode classes, opcode[7:5]
`define GRP_JUMP      3'h4
`define GRP_BIT       3'h5
`define GRP_ALU       3'h6
`define GRP_SHORT     3'h7

// Short branch conditions, opcode[6:5]
`define COND_ZERO_CLEAR  2'h0
`define COND_ZERO_SET    2'h1
`define COND_CARRY_CLEAR 2'h2
`define COND_CARRY_SET   2'h3

// Operand modes in the ALU class, opcode[1:0]
`define MODE_IND_X    2'h0
`define MODE_IND_Y    2'h1
`define MODE_DIRECT   2'h2
`define MODE_IMM      2'h3

// ALU class operations, opcode[4:2]
`define AOP_LOAD      3'h0
`define AOP_ADD       3'h1
`define AOP_AND       3'h2
`define AOP_CMP       3'h3
`define AOP_SUB       3'h4
`define AOP_STORE     3'h5
`define AOP_INC       3'h6
`define AOP_DEC       3'h7

// Short class sub-groups, opcode[4:2]
`define SOP_LOAD      3'h0
`define SOP_STORE     3'h1
`define SOP_INC       3'h2
`define SOP_DEC       3'h3
`define SOP_ACC       3'h4
`define SOP_CTRL      3'h5
`define SOP_MISC      3'h6

////////////////////////////////////////////////////////////////////////////////
// ALU function select
`define ALU_PASS      4'h0
`define ALU_ADD       4'h1
`define ALU_AND       4'h2
`define ALU_SUB       4'h3
`define ALU_INC       4'h4
`define ALU_DEC       4'h5
`define ALU_COM       4'h6
`define ALU_RLC       4'h7
`define ALU_SLA       4'h8
`define ALU_CLR       4'h9

////////////////////////////////////////////////////////////////////////////////
// Cycle counts and addresses
`define CYC_SHORT     3'h2
`define CYC_NORMAL    3'h4
`define CYC_BIT_TEST  3'h5
`define SHORT_BASE    6'h20
`define RESET_PC      12'h000
`define STACK_DEPTH   6

`endif

// file: alu8.v
// Eight-bit ALU for the instruction core
// Assumes function codes from core_defines.vh; purely combinational
`timescale 1ns/1ps
`include "core_defines.vh"

module alu8 (
  input  wire [3:0] func,
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire       carry_in,
  output reg  [7:0] result,
  output reg        carry_out,
  output wire       zero
);

  reg [8:0] wide;

  always @* begin
    wide      = 9'h000;
    result    = b;
    carry_out = carry_in;
    case (func)
      `ALU_ADD: begin
        wide      = {1'b0, a} + {1'b0, b};
        result    = wide[7:0];
        carry_out = wide[8]; // RQ4
      end
      `ALU_AND: begin
        result    = a & b;
        carry_out = 1'b0;
      end
      `ALU_SUB: begin
        result    = a - b;
        carry_out = (a < b); // RQ4
      end
      `ALU_INC: result = b + 8'h01;
      `ALU_DEC: result = b - 8'h01;
      `ALU_COM: begin
        result    = ~a;
        carry_out = a[7]; // RQ6
      end
      `ALU_RLC: begin
        result    = {a[6:0], carry_in};
        carry_out = a[7]; // RQ6
      end
      `ALU_SLA: begin
        result    = {a[6:0], 1'b0};
        carry_out = a[7]; // RQ6
      end
      `ALU_CLR: begin
        result    = 8'h00;
        carry_out = 1'b0; // RQ5
      end
      default: result = b;
    endcase
  end

  assign zero = (result == 8'h00); // RQ18

endmodule

// file: mem_model.sv
// Program and data memory model beside the instruction core
// Assumes asynchronous reads and a write on the rising edge with data_we
`timescale 1ns/1ps
module mem_model (
  input  wire        clock,
  input  wire [11:0] prog_addr,
  output wire [7:0]  prog_data,
  input  wire [7:0]  data_addr,
  output wire [7:0]  data_rdata,
  input  wire [7:0]  data_wdata,
  input  wire        data_we
);
  reg [7:0] prog_mem [0:4095];
  reg [7:0] data_mem [0:255];

  assign prog_data  = prog_mem[prog_addr];
  assign data_rdata = data_mem[data_addr];

  always @(posedge clock) begin
    if (data_we) begin
      data_mem[data_addr] <= data_wdata;
    end
  end
endmodule

// file: instruction_core_chk.sv
// Port checker for the instruction core
// Assumes one clock domain; bound to instruction_core below
`timescale 1ns/1ps
module instruction_core_chk (
  input wire        clock,
  input wire        reset_n,
  input wire [11:0] prog_addr,
  input wire        data_we,
  input wire        watchdog_on,
  input wire        wake,
  input wire [7:0]  acc_value,
  input wire        zero_flag,
  input wire        carry_flag,
  input wire        waiting,
  input wire        stopped
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_we_pulse; data_we |=> !data_we; endproperty
  property p_we_carry; data_we |=> $stable(carry_flag); endproperty
  property p_we_acc; data_we |=> $stable(acc_value); endproperty
  property p_halt_excl; !(waiting && stopped); endproperty
  property p_stop_wd; $rose(stopped) |-> !watchdog_on; endproperty
  property p_wake; (waiting || stopped) && wake |=> !(waiting || stopped); endproperty
  property p_halt_fetch; (waiting || stopped) && !wake |=> $stable(prog_addr); endproperty
  property p_halt_flags;
    (waiting || stopped) && !wake |=> $stable(zero_flag) && $stable(carry_flag);
  endproperty
  property p_zero; $changed(acc_value) |-> zero_flag == (acc_value == 8'h00); endproperty

  a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
  a_we_carry: assert property (p_we_carry) else $error("write changed carry");
  a_we_acc: assert property (p_we_acc) else $error("write changed accumulator");
  a_halt_excl: assert property (p_halt_excl) else $error("wait and stop together");
  a_stop_wd: assert property (p_stop_wd) else $error("stop with watchdog on");
  a_wake: assert property (p_wake) else $error("wake ignored");
  a_halt_fetch: assert property (p_halt_fetch) else $error("fetch moved in halt");
  a_halt_flags: assert property (p_halt_flags) else $error("flags moved in halt");
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  c_write: cover property (data_we);
  c_stop: cover property ($rose(stopped));
  c_wait_carry: cover property ($rose(waiting) && carry_flag);
endmodule

bind instruction_core instruction_core_chk chk (
  .clock(clock), .reset_n(reset_n), .prog_addr(prog_addr), .data_we(data_we),
  .watchdog_on(watchdog_on), .wake(wake), .acc_value(acc_value), .zero_flag(zero_flag),
  .carry_flag(carry_flag), .waiting(waiting), .stopped(stopped));

// file: tb.sv
// Self-checking bench for the instruction core
// Assumes mem_model as program and data memory; programs end in wait
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error %0t: got %h expected %h", $time, got, exp); end end
module tb;
  reg         clock;
  reg         reset_n;
  reg         watchdog_on;
  reg         wake;
  wire [11:0] prog_addr;
  wire [7:0]  prog_data;
  wire [7:0]  data_addr;
  wire [7:0]  data_rdata;
  wire [7:0]  data_wdata;
  wire        data_we;
  wire [7:0]  acc_value;
  wire        zero_flag;
  wire        carry_flag;
  wire        waiting;
  wire        stopped;
  integer     error_cnt;
  integer     samples_checked;
  integer     seed;
  integer     cyc;
  integer     t0;
  integer     i;
  integer     k;
  reg  [11:0] pa;
  reg  [7:0]  a;
  reg  [7:0]  b;
  reg  [7:0]  v;
  reg  [7:0]  p;
  reg  [7:0]  w;
  reg         tk;

  instruction_core DUT (
    .clock(clock), .reset_n(reset_n), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_addr(data_addr), .data_rdata(data_rdata), .data_wdata(data_wdata),
    .data_we(data_we), .watchdog_on(watchdog_on), .wake(wake), .acc_value(acc_value),
    .zero_flag(zero_flag), .carry_flag(carry_flag), .waiting(waiting), .stopped(stopped));

  mem_model mem (
    .clock(clock), .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
    .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we));

  ////////////////////////////////////////////////////////////////////////////////
  function [9:0] alu_exp(input [2:0] op, input [7:0] x, input [7:0] y);
    reg [8:0] r;
    begin
      case (op)
        3'h1: r = {1'b0, x} + {1'b0, y};
        3'h2: r = {1'b0, x & y};
        default: r = {1'b0, x} - {1'b0, y};
      endcase
      alu_exp = {(op == 3'h3) ? x : r[7:0], r[7:0] == 8'h00, r[8]};
    end
  endfunction

  function [9:0] acc_exp(input [1:0] kd, input [7:0] x, input cin);
    reg [8:0] r;
    begin
      case (kd)
        2'h0: r = {x[7], ~x};
        2'h1: r = {x, cin};
        2'h2: r = {x, 1'b0};
        default: r = 9'h000;
      endcase
      acc_exp = {r[7:0], r[7:0] == 8'h00, r[8]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task pb(input [7:0] x);
    begin
      mem.prog_mem[pa] = x;
      pa = pa + 12'h001;
    end
  endtask

  task setup;
    begin
      @(negedge clock);
      reset_n = 1'b0;
      for (i = 0; i < 4096; i = i + 1) mem.prog_mem[i] = 8'hf8;
      for (i = 0; i < 256; i = i + 1) mem.data_mem[i] = $random(seed);
      pa = 12'h000;
    end
  endtask

  task halt_wait;
    begin
      cyc = 0;
      while (cyc < 300 && !(waiting || stopped)) begin
        @(posedge clock);
        #1;
        cyc = cyc + 1;
      end
    end
  endtask

  task go;
    begin
      repeat (6) @(negedge clock);
      reset_n = 1'b1;
      halt_wait;
    end
  endtask

  task chk_state(input [9:0] e);
    begin
      `CHK(acc_value, e[9:2])
      `CHK(zero_flag, e[1])
      `CHK(carry_flag, e[0])
    end
  endtask

  task complete_run;
    begin
      $display("Checks %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    #500000;
    error_cnt = error_cnt + 1;
    complete_run;
  end

  initial begin
    seed = 79;
    error_cnt = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    watchdog_on = 1'b0;
    wake = 1'b0;
    setup;
    go;
    `CHK(cyc, 2)
    t0 = cyc;
    // Immediate arithmetic, equal operands first
    for (k = 0; k < 16; k = k + 1) begin
      setup;
      a = $random(seed);
      b = (k < 4) ? a : $random(seed);
      pb(8'hc3); pb(a); pb(8'hc3 | 8'((k % 4 + 1) << 2)); pb(b);
      go;
      chk_state(alu_exp(3'(k % 4 + 1), a, b));
      `CHK(cyc, t0 + 8)
    end
    // Accumulator operations after a compare
    for (k = 0; k < 8; k = k + 1) begin
      setup;
      a = $random(seed);
      b = (k < 4) ? 8'hff : $random(seed);
      pb(8'hc3); pb(a); pb(8'hcf); pb(b); pb(8'hf0 | 8'(k % 4));
      if (k % 4 > 1) pb(8'h00);
      go;
      chk_state(acc_exp(2'(k % 4), a, a < b));
      `CHK(cyc, t0 + 12)
    end
    // Store, immediate store, decrement and clear of memory
    for (k = 0; k < 4; k = k + 1) begin
      setup;
      a = $random(seed);
      p = $random(seed);
      v = (k == 0) ? 8'h01 : $random(seed);
      pb(8'hc3); pb(a); pb(8'hcf); pb(8'hff); pb(8'hd6); pb(p);
      pb(8'hd7); pb(p ^ 8'h55); pb(v); pb(8'hde); pb(p ^ 8'h55);
      pb(8'hfb); pb(p ^ 8'h0f); pb(8'h00);
      go;
      `CHK(mem.data_mem[p], a)
      `CHK(mem.data_mem[p ^ 8'h55], v - 8'h01)
      `CHK(mem.data_mem[p ^ 8'h0f], 8'h00)
      chk_state({a, v == 8'h01, a != 8'hff});
      `CHK(cyc, t0 + 24)
    end
    // Bit write then bit test branch
    for (k = 0; k < 8; k = k + 1) begin
      setup;
      p = $random(seed);
      b = 8'(k / 4 * 5 + k % 2 * 2);
      v = mem.data_mem[p];
      v[b[2:0]] = k[0];
      tk = k[0] == k[1];
      pb(8'ha0 | {4'h0, k[0], b[2:0]}); pb(p);
      pb(8'hb0 | {4'h0, k[1], b[2:0]}); pb(p); pb(8'h03); pb(8'hc3); pb(8'h11);
      go;
      `CHK(mem.data_mem[p], v)
      chk_state({tk ? 8'h00 : 8'h11, 1'b0, k[0]});
      `CHK(cyc, t0 + (tk ? 9 : 13))
    end
    // Short branches over every condition and each flag pair but zero and carry both set
    for (k = 0; k < 12; k = k + 1) begin
      setup;
      a = (k < 4) ? 8'h05 : (k < 8) ? 8'h03 : 8'h07;
      b = (k < 4) ? 8'h05 : (k < 8) ? 8'h07 : 8'h03;
      case (k % 4)
        0: tk = a != b;
        1: tk = a == b;
        2: tk = a >= b;
        default: tk = a < b;
      endcase
      pb(8'hc3); pb(a); pb(8'hcf); pb(b); pb({1'b0, 2'(k % 4), 5'h02}); pb(8'hc3); pb(8'h11);
      go;
      chk_state({tk ? a : 8'h11, tk && a == b, a < b});
      `CHK(cyc, t0 + (tk ? 10 : 14))
    end
    // Far jump, call and interrupt return
    setup;
    pb(8'h8a); pb(8'h30);
    pa = 12'ha30;
    pb(8'hc3); pb(8'h03); pb(8'hcf); pb(8'h07); pb(8'h9b); pb(8'h00);
    pa = 12'hb00;
    pb(8'hc3); pb(8'h00); pb(8'hf6);
    go;
    chk_state({8'h00, 1'b0, 1'b1});
    `CHK(cyc, t0 + 22)
    // Pointer and short-direct access, call and return, backward branch
    setup;
    p = $random(seed);
    p[7] = 1'b0;
    p[0] = 1'b1;
    a = $random(seed);
    b = $random(seed);
    v = a + b + 8'h01;
    pb(8'hc3); pb(p); pb(8'he4); pb(8'hc3); pb(a); pb(8'hd4); pb(8'hc3); pb(b);
    pb(8'hc4); pb(8'heb); pb(8'h91); pb(8'h10); pb(8'h80); pb(8'h20);
    pa = 12'h110;
    pb(8'hf4); pb(8'hf9); pb(8'h00); pb(8'hf5);
    pa = 12'h020;
    pb(8'hcf); pb(v); pb(8'h34); pb(8'hc3); pb(8'h5a);
    w = mem.data_mem[8'h83];
    go;
    `CHK(mem.data_mem[8'h80], p)
    `CHK(mem.data_mem[p], a)
    `CHK(mem.data_mem[8'h83], w + 8'h01)
    chk_state({v, 1'b1, 1'b0});
    `CHK(cyc, t0 + 50)
    // Stop with and without the watchdog, then wake
    for (k = 0; k < 2; k = k + 1) begin
      setup;
      watchdog_on = k[0];
      pb(8'hf7); pb(8'hc3); pb(8'h33);
      go;
      `CHK(stopped, ~k[0])
      `CHK(waiting, k[0])
      `CHK(cyc, t0)
      @(negedge clock);
      wake = 1'b1;
      @(negedge clock);
      wake = 1'b0;
      halt_wait;
      `CHK(acc_value, 8'h33)
    end
    complete_run;
  end
endmodule
